// file: design/cavr_ca_ref_reg.sv
`timescale 1ns/1ps
`include "cavr_map.svh"

module cavr_ca_ref_reg (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_in,
  // Mode register command
  input  wire cavr_pkg::cavr_cmd_t  cmd_in,
  // Set-point select bits from the set-point control register
  input  wire logic                 setpoint_write_select_in,
  input  wire logic                 setpoint_operate_select_in,
  // Read answer
  output cavr_pkg::cavr_rsp_t       rsp_out,
  // Active reference setting to the receiver
  output cavr_pkg::cavr_copy_t      active_out,
  output logic                      active_reserved_out
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Copy chosen by a select bit
  function automatic cavr_pkg::cavr_copy_t pick(input logic sel,
                                                input cavr_pkg::cavr_copy_t a,
                                                input cavr_pkg::cavr_copy_t b);
    pick = sel ? b : a;
  endfunction

  // Codes above the valid span are reserved in either range
  function automatic logic is_reserved(input logic [5:0] code);
    is_reserved = (code > `CAVR_LEVEL_MAX);
  endfunction

  // --------------------------------------------------------------------------
  // Module state
  // --------------------------------------------------------------------------
  typedef struct packed {
    cavr_pkg::cavr_state_t st;       // Read pipeline state
    cavr_pkg::cavr_rsp_t   rsp;      // Registered answer
    cavr_pkg::cavr_copy_t  act;      // Registered active copy
    logic                  act_rsv;  // Active code reserved
  } cavr_top_t;

  cavr_top_t state_reg;              // Registered state
  cavr_top_t state_next;             // Next state

  cavr_pkg::cavr_copy_t copy0;       // Set point 0 copy
  cavr_pkg::cavr_copy_t copy1;       // Set point 1 copy
  cavr_pkg::cavr_copy_t wr_copy;     // Write operand split into fields
  cavr_pkg::cavr_copy_t rd_copy;     // Copy seen by reads
  logic                 hit;         // Command targets this register

  assign hit = (cmd_in.addr == `CAVR_REG_ADDR);

  // Range and level are taken from one write, never separately
  assign wr_copy.range = cmd_in.data[`CAVR_RANGE_BIT];
  assign wr_copy.level = cmd_in.data[`CAVR_LEVEL_MSB:`CAVR_LEVEL_LSB];

  // --------------------------------------------------------------------------
  // Copy storage
  // --------------------------------------------------------------------------
  cavr_copy_store u_store (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .wr_en_in   (cmd_in.wr && hit),
    .wr_sel_in  (setpoint_write_select_in),
    .wr_data_in (wr_copy),
    .copy0_out  (copy0),
    .copy1_out  (copy1)
  );

  // Reads see the write-selected copy, not the operating one
  assign rd_copy = pick(setpoint_write_select_in, copy0, copy1);

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // Receiver follows only the operate-selected copy
    state_next.act     = pick(setpoint_operate_select_in, copy0, copy1);
    state_next.act_rsv = is_reserved(state_next.act.level);
    case (state_reg.st)
      cavr_pkg::CAVR_IDLE: begin
        state_next.rsp.valid = 1'b0;
        state_next.rsp.dq    = `CAVR_ZERO16;
        if (cmd_in.rd && hit) begin
          // Answer one cycle after the read strobe
          state_next.st                   = cavr_pkg::CAVR_ANSWER;
          state_next.rsp.valid            = 1'b1;
          state_next.rsp.dq               = `CAVR_ZERO16;
          state_next.rsp.dq[`CAVR_LEVEL_MSB:`CAVR_LEVEL_LSB] = rd_copy.level;
          state_next.rsp.dq[`CAVR_RANGE_BIT] = rd_copy.range;
          state_next.rsp.dq[`CAVR_RSVD_BIT]  = 1'b0;
        end
      end
      cavr_pkg::CAVR_ANSWER: begin
        // One-cycle answer, then lanes back to zero
        state_next.st        = cavr_pkg::CAVR_IDLE;
        state_next.rsp.valid = 1'b0;
        state_next.rsp.dq    = `CAVR_ZERO16;
      end
      default: begin
        state_next.st        = cavr_pkg::CAVR_IDLE;
        state_next.rsp.valid = 1'b0;
        state_next.rsp.dq    = `CAVR_ZERO16;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg.st        <= cavr_pkg::CAVR_IDLE;
      state_reg.rsp.valid <= 1'b0;
      state_reg.rsp.dq    <= `CAVR_ZERO16;
      state_reg.act.range <= `CAVR_RANGE_RESET;
      state_reg.act.level <= `CAVR_LEVEL_RESET;
      state_reg.act_rsv   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rsp_out             = state_reg.rsp;
  assign active_out          = state_reg.act;
  assign active_reserved_out = state_reg.act_rsv;

endmodule // cavr_ca_ref_reg

// file: design/cavr_map.svh
`ifndef CAVR_MAP_SVH
`define CAVR_MAP_SVH

// ----------------------------------------------------------------------------
// Register address and field layout
// ----------------------------------------------------------------------------
`define CAVR_REG_ADDR        6'h0C
`define CAVR_LEVEL_MSB       5
`define CAVR_LEVEL_LSB       0
`define CAVR_RANGE_BIT       6
`define CAVR_RSVD_BIT        7
`define CAVR_WSEL_BIT        6
`define CAVR_OSEL_BIT        7

// ----------------------------------------------------------------------------
// Reset values and code limits
// ----------------------------------------------------------------------------
`define CAVR_LEVEL_RESET     6'h0D
`define CAVR_RANGE_RESET     1'h1
`define CAVR_LEVEL_MAX       6'h32
`define CAVR_ZERO8           8'h00
`define CAVR_ZERO16          16'h0000

`endif

// file: design/cavr_pkg.sv
package cavr_pkg;

  // --------------------------------------------------------------------------
  // One set-point copy of the register
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       range;   // Reference range select
    logic [5:0] level;   // Reference level code
  } cavr_copy_t;

  // Mode register command from the command decoder
  typedef struct packed {
    logic       wr;      // Write strobe
    logic       rd;      // Read strobe
    logic [5:0] addr;    // Mode register address
    logic [7:0] data;    // Write operand
  } cavr_cmd_t;

  // Read answer
  typedef struct packed {
    logic        valid;  // Read data valid
    logic [15:0] dq;     // Data lane contents
  } cavr_rsp_t;

  // Read pipeline state
  typedef enum logic {
    CAVR_IDLE,
    CAVR_ANSWER
  } cavr_state_t;

endpackage

// file: design/cavr_copy_store.sv
`timescale 1ns/1ps
`include "cavr_map.svh"

module cavr_copy_store (
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                reset_in,
  // Write access
  input  wire logic                wr_en_in,
  input  wire logic                wr_sel_in,
  input  wire cavr_pkg::cavr_copy_t wr_data_in,
  // Stored copies
  output cavr_pkg::cavr_copy_t     copy0_out,
  output cavr_pkg::cavr_copy_t     copy1_out
);

  // --------------------------------------------------------------------------
  // State: both set-point copies
  // --------------------------------------------------------------------------
  typedef struct packed {
    cavr_pkg::cavr_copy_t c0;  // Set point 0 copy
    cavr_pkg::cavr_copy_t c1;  // Set point 1 copy
  } cavr_store_t;

  cavr_store_t state_reg;      // Registered state
  cavr_store_t state_next;     // Next state

  // Only the selected copy takes the write; the other holds
  always_comb begin
    state_next = state_reg;
    if (wr_en_in) begin
      if (wr_sel_in) begin
        state_next.c1 = wr_data_in;
      end else begin
        state_next.c0 = wr_data_in;
      end
    end
  end

  // Power-on or reset brings both copies to defaults
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg.c0.range <= `CAVR_RANGE_RESET;
      state_reg.c0.level <= `CAVR_LEVEL_RESET;
      state_reg.c1.range <= `CAVR_RANGE_RESET;
      state_reg.c1.level <= `CAVR_LEVEL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign copy0_out = state_reg.c0;
  assign copy1_out = state_reg.c1;

endmodule // cavr_copy_store

// file: test/cavr_checker.sv
`timescale 1ns/1ps
module cavr_checker (
  // Clock, reset, inputs and outputs of the register
  input wire logic                 ref_clk_in,
  input wire logic                 reset_in,
  input wire cavr_pkg::cavr_cmd_t  cmd_in,
  input wire logic                 setpoint_write_select_in,
  input wire logic                 setpoint_operate_select_in,
  input wire cavr_pkg::cavr_rsp_t  rsp_out,
  input wire cavr_pkg::cavr_copy_t active_out,
  input wire logic                 active_reserved_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire logic hit = cmd_in.addr == 6'h0C; // Command aimed here
  // Read taken outside an answer cycle
  sequence s_rd; cmd_in.rd && hit && !rsp_out.valid; endsequence
  // Write to the active copy, operate select then held
  sequence s_wr_act;
    cmd_in.wr && hit && setpoint_write_select_in == setpoint_operate_select_in ##1 $stable(setpoint_operate_select_in);
  endsequence
  a_read_answer: assert property (s_rd |=> rsp_out.valid && rsp_out.dq[15:7] == 9'h000) else $error("read unanswered");
  a_valid_cause: assert property (rsp_out.valid |-> $past(cmd_in.rd && hit)) else $error("valid without read");
  a_valid_pulse: assert property (rsp_out.valid |=> !rsp_out.valid) else $error("valid too long");
  a_idle_zero: assert property (!rsp_out.valid |-> rsp_out.dq == 16'h0000) else $error("lanes not zero");
  a_write_active: assert property (s_wr_act |=> active_out == $past(cmd_in.data[6:0], 2)) else $error("write lost");
  a_inactive_hold: assert property (!(cmd_in.wr && hit && setpoint_write_select_in == setpoint_operate_select_in)
    ##1 $stable(setpoint_operate_select_in) |=> $stable(active_out)) else $error("active disturbed");
  a_read_copy: assert property (cmd_in.rd && hit && !rsp_out.valid
    && setpoint_write_select_in == $past(setpoint_operate_select_in)
    && !$past(cmd_in.wr && hit) |=> rsp_out.dq[6:0] == $past(active_out)) else $error("wrong copy read");
  a_reset_default: assert property ($fell(reset_in) |-> active_out == 7'h4D && !active_reserved_out)
    else $error("bad reset value");
endmodule // cavr_checker

// file: test/cavr_ctrl_model.sv
`timescale 1ns/1ps
module cavr_ctrl_model (
  // Clock
  input  wire logic           ref_clk_in,
  // Command and set-point selects
  output cavr_pkg::cavr_cmd_t cmd_out,
  output logic                wsel_out,
  output logic                osel_out
);
  logic [6:0]  cp_reg [2]; // Mirror of both copies
  logic [15:0] exp_q [$];  // Expected read answers
  logic        rd_reg;     // Last command was a taken read
  // Mirror returns to reset defaults
  function automatic void clr();
    cp_reg = '{7'h4D, 7'h4D};
  endfunction
  initial begin
    cmd_out = '0;
    {wsel_out, osel_out, rd_reg} = 3'h0;
    clr();
  end
  // One command per edge; calls in a row go back to back
  task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    cmd_out <= {w, ~w, a, d};
    if (w && a == 6'h0C) cp_reg[wsel_out] = d[6:0];
    if (!w && a == 6'h0C && !rd_reg) exp_q.push_back({9'h000, cp_reg[wsel_out]});
    rd_reg = !w && a == 6'h0C && !rd_reg; // Second read in a row is refused
  endtask
  // Strobes drop; operand lines toggle so stale values never linger
  task automatic idle();
    @(posedge ref_clk_in);
    cmd_out <= {2'b00, ~cmd_out.addr, ~cmd_out.data};
    rd_reg = 1'b0;
  endtask
  task automatic sel(input logic w, input logic o);
    @(posedge ref_clk_in);
    {wsel_out, osel_out} <= {w, o};
    rd_reg = 1'b0; // A read two edges back is taken again
  endtask
endmodule // cavr_ctrl_model

// file: test/cavr_ca_ref_reg_tb.sv
`timescale 1ns/1ps
module cavr_ca_ref_reg_tb;
  logic                 ref_clk_in = 1'b0; // 25 MHz
  logic                 reset_in = 1'b1;   // Held 16 cycles
  cavr_pkg::cavr_cmd_t  cmd;               // Command from the model
  logic                 wsel, osel;        // Set-point selects
  cavr_pkg::cavr_rsp_t  rsp;               // Read answer
  cavr_pkg::cavr_copy_t act;               // Active setting
  logic                 rsv;               // Reserved code flag
  integer n_mismatch = 0, checked = 0, seed = 32'h26c6ec4d, i;
  logic [7:0] d;
  always #20 ref_clk_in = ~ref_clk_in;
  cavr_ctrl_model u_cavr_ctrl_model (.ref_clk_in(ref_clk_in), .cmd_out(cmd), .wsel_out(wsel), .osel_out(osel));
  cavr_ca_ref_reg u_cavr_ca_ref_reg (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .cmd_in(cmd),
    .setpoint_write_select_in(wsel), .setpoint_operate_select_in(osel), .rsp_out(rsp), .active_out(act),
    .active_reserved_out(rsv));
  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic cmp_act(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, got, exp); end
  endtask
  // Active copy settles two edges after the last change
  task automatic chk_act();
    u_cavr_ctrl_model.idle();
    repeat (3) @(negedge ref_clk_in);
    cmp_act({rsv, act}, {u_cavr_ctrl_model.cp_reg[osel][5:0] > 6'h32, u_cavr_ctrl_model.cp_reg[osel]});
  endtask
  // Answers checked mid-cycle, oldest note first; an unexpected one always fails
  always @(negedge ref_clk_in) if (rsp.valid === 1'b1) begin
    if (u_cavr_ctrl_model.exp_q.size() == 0) cmp_rd(rsp.dq, ~rsp.dq);
    else cmp_rd(rsp.dq, u_cavr_ctrl_model.exp_q.pop_front());
  end
  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    for (i = 0; i < 2; i++) begin
      u_cavr_ctrl_model.sel(i[0], i[0]);
      u_cavr_ctrl_model.cmd(0, 6'h0C, 8'h00);
      chk_act();
    end
    $display("reset defaults done");
    // Random writes, a foreign address, bit 7 random, read at once
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      u_cavr_ctrl_model.sel(d[0], d[1]);
      d[5:0] = 6'({$random(seed)} % 51);
      u_cavr_ctrl_model.cmd(1, 6'h0C, d);
      u_cavr_ctrl_model.cmd(1, 6'h0B, ~d);
      u_cavr_ctrl_model.cmd(0, 6'h0C, 8'h00);
      chk_act();
    end
    $display("random writes done");
    // Inactive copy written at the top code, back-to-back reads, then switch
    u_cavr_ctrl_model.sel(1, 0);
    u_cavr_ctrl_model.cmd(1, 6'h0C, 8'h72);
    u_cavr_ctrl_model.cmd(0, 6'h0C, 8'h00);
    u_cavr_ctrl_model.cmd(0, 6'h0C, 8'h00);
    chk_act();
    u_cavr_ctrl_model.sel(0, 1);
    chk_act();
    // Reserved code on the active copy raises the flag
    u_cavr_ctrl_model.sel(1, 1);
    u_cavr_ctrl_model.cmd(1, 6'h0C, 8'h3F);
    chk_act();
    $display("set point switch done");
    // Values hold while idle, then a mid-run reset restores defaults
    repeat (50) @(posedge ref_clk_in);
    u_cavr_ctrl_model.cmd(0, 6'h0C, 8'h00);
    u_cavr_ctrl_model.idle();
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b1;
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    u_cavr_ctrl_model.clr();
    u_cavr_ctrl_model.cmd(0, 6'h0C, 8'h00);
    chk_act();
    $display("hold and reset done");
    results();
  end
endmodule // cavr_ca_ref_reg_tb
bind cavr_ca_ref_reg cavr_checker u_cavr_checker (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .cmd_in(cmd_in),
  .setpoint_write_select_in(setpoint_write_select_in), .setpoint_operate_select_in(setpoint_operate_select_in),
  .rsp_out(rsp_out), .active_out(active_out), .active_reserved_out(active_reserved_out));
